/* hw/shc_pkg.sv */
// shared constants for the standby hold controller
// How it works
// - standby from low-speed stops the low oscillator
// - standby always resumes in full-speed mode
// - single-clock mode: high oscillator only, pins are I/O
// - clock status bit0: pin level or operating state
// - auxiliary status bit3 always shows standby pin
// - standby command works from full or low speed
// - standby stops oscillator and halts the core
// - entering standby clears the interval timer
// - core state kept intact across standby
// - resume address held during standby
// - level mode: pin high releases standby
// - level mode: command with pin high warms up
// - edge mode: rising pin edge releases standby
// - edge mode: enters standby even with pin high
// - release restarts oscillator, core stopped during warm-up
// - three software-selectable warm-up durations
// - warm-up timed by interval timer stages
// - after warm-up execution resumes at next instruction
// - reset during standby releases into normal reset
// - dual-clock bit0 shows low-speed versus full-speed
package shc_pkg;
  localparam int ADR_W = 8;
  localparam logic [7:0] OFS_STANDBY_CMD = 8'h00;
  localparam logic [7:0] OFS_CLOCK_CTRL = 8'h04;
  localparam logic [7:0] OFS_CLOCK_STAT = 8'h08;
  localparam logic [7:0] OFS_AUX_STAT = 8'h0c;
  localparam logic [7:0] OFS_RESUME_PC = 8'h10;
  // standby command port fields
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_WU_LSB = 1;
  localparam int CMD_EDGE_BIT = 3;
  // clock control command port fields
  localparam int CTL_DUAL_BIT = 0;
  localparam int CTL_SLOW_BIT = 1;
  // status fields
  localparam int STAT_STATE_BIT = 0;
  localparam int STAT_LOOSC_BIT = 1;
  localparam int AUX_PIN_BIT = 3;
  localparam logic [1:0] WU_SEL_RST = 2'h0;
  localparam logic [1:0] WU_SEL_SHORT = 2'h0;
  localparam logic [1:0] WU_SEL_MID = 2'h1;
  typedef enum logic [1:0] {SHC_RUN_FULL, SHC_RUN_SLOW, SHC_STANDBY, SHC_WARMUP} shc_state_e;
endpackage

/* hw/shc_timer_if.sv */
// carrier between the controller and its interval timer
`timescale 1ns/100ps
interface shc_timer_if #(parameter int TIMER_W = 20);
  logic clear;
  logic run;
  logic [TIMER_W-1:0] count;
  modport ctrl (output clear, output run, input count);
  modport timer (input clear, input run, output count);
endinterface

/* hw/shc_sync.sv */
// two-flop synchroniser for a pin level
`timescale 1ns/100ps
module shc_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic pinIn,
  output logic pinOut
);
  logic meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      pinOut <= 1'b0;
    end else if (ce) begin
      meta_r <= pinIn;
      pinOut <= meta_r;
    end
  end
endmodule

/* hw/shc_interval_timer.sv */
// divider chain with clear and run inputs, used to time the warm-up
`timescale 1ns/100ps
module shc_interval_timer #(
  parameter int TIMER_W = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  shc_timer_if.timer tmr
);
  initial begin
    if (TIMER_W < 2 || TIMER_W > 31) $error("shc_interval_timer: TIMER_W out of range");
  end

  logic [TIMER_W-1:0] count_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (ce) begin
      if (tmr.clear) begin
        count_r <= '0;
      end else if (tmr.run) begin
        count_r <= count_r + 1'b1;
      end
    end
  end

  assign tmr.count = count_r;
endmodule

/* hw/standby_hold_controller.sv */
// standby hold controller with a classic wishbone register slave
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module standby_hold_controller #(
  parameter int TIMER_W = 20,
  parameter int PC_W = 12,
  parameter int WU_TAP0 = 12,
  parameter int WU_TAP1 = 14,
  parameter int WU_TAP2 = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [shc_pkg::ADR_W-1:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // core side
  input wire logic [PC_W-1:0] nextPc,
  output logic coreRunEn,
  output logic [PC_W-1:0] resumePc,
  // oscillator and pin side
  input wire logic standbyPin,
  output logic hiOscEn,
  output logic loOscEn,
  output logic lowOscPinsAsIo,
  output logic inStandby
);
  initial begin
    if (!(WU_TAP0 < WU_TAP1 && WU_TAP1 < WU_TAP2 && WU_TAP2 < TIMER_W && WU_TAP0 > 0)) begin
      $error("standby_hold_controller: warm-up taps must rise and fit the timer");
    end
    if (PC_W < 1 || PC_W > 32) $error("standby_hold_controller: PC_W out of range");
  end

  shc_pkg::shc_state_e state_r;
  shc_pkg::shc_state_e state_nxt;
  logic pinSync;
  logic pinPrev_r;
  logic pinRise;
  logic dualMode_r;
  logic slowReq_r;
  logic edgeMode_r;
  logic [1:0] wuSel_r;
  logic warmDone;
  logic busReq;
  logic wrLow;
  logic cmdGo;
  logic cmdEdge;
  logic [1:0] cmdWuSel;
  logic ctlWrite;
  logic [31:0] rdData;
  logic [shc_pkg::ADR_W-1:0] adrHit;

  shc_timer_if #(.TIMER_W(TIMER_W)) tmrBus ();

  shc_sync pinSyncer (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pinIn(standbyPin),
    .pinOut(pinSync)
  );

  shc_interval_timer #(.TIMER_W(TIMER_W)) intervalTimer (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .tmr(tmrBus.timer)
  );

  // bus decode: one request per ack, only byte lane 0 carries writable fields
  assign busReq = cyc_i && stb_i && !ack_o;
  assign adrHit = adr_i;
  assign wrLow = busReq && we_i && sel_i[0];
  assign cmdGo = wrLow && (adrHit == shc_pkg::OFS_STANDBY_CMD) && dat_i[shc_pkg::CMD_GO_BIT];
  assign cmdEdge = dat_i[shc_pkg::CMD_EDGE_BIT];
  assign cmdWuSel = dat_i[shc_pkg::CMD_WU_LSB +: 2];
  assign ctlWrite = wrLow && (adrHit == shc_pkg::OFS_CLOCK_CTRL);

  // second flop of the syncer is registered once more for the edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinPrev_r <= 1'b0;
    end else if (ce) begin
      pinPrev_r <= pinSync;
    end
  end
  assign pinRise = pinSync && !pinPrev_r;

  // warm-up ends when the selected divider stage first goes high
  always_comb begin
    case (wuSel_r)
      shc_pkg::WU_SEL_SHORT: warmDone = tmrBus.count[WU_TAP0];
      shc_pkg::WU_SEL_MID: warmDone = tmrBus.count[WU_TAP1];
      default: warmDone = tmrBus.count[WU_TAP2];
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      shc_pkg::SHC_RUN_FULL: begin
        if (cmdGo) begin
          // level mode refuses to sleep while the pin already asks to wake
          if (!cmdEdge && pinSync) begin
            state_nxt = shc_pkg::SHC_WARMUP;
          end else begin
            state_nxt = shc_pkg::SHC_STANDBY;
          end
        end else if (dualMode_r && slowReq_r) begin
          state_nxt = shc_pkg::SHC_RUN_SLOW;
        end
      end
      shc_pkg::SHC_RUN_SLOW: begin
        if (cmdGo) begin
          if (!cmdEdge && pinSync) begin
            state_nxt = shc_pkg::SHC_WARMUP;
          end else begin
            state_nxt = shc_pkg::SHC_STANDBY;
          end
        end else if (!slowReq_r || !dualMode_r) begin
          state_nxt = shc_pkg::SHC_WARMUP;
        end
      end
      shc_pkg::SHC_STANDBY: begin
        if (edgeMode_r ? pinRise : pinSync) begin
          state_nxt = shc_pkg::SHC_WARMUP;
        end
      end
      shc_pkg::SHC_WARMUP: begin
        if (warmDone) begin
          state_nxt = shc_pkg::SHC_RUN_FULL;
        end
      end
      default: state_nxt = shc_pkg::SHC_RUN_FULL;
    endcase
  end

  // reset at any time, standby included, returns straight to normal run
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= shc_pkg::SHC_RUN_FULL;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // mode and warm-up choice latched only when a command is accepted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edgeMode_r <= 1'b0;
      wuSel_r <= shc_pkg::WU_SEL_RST;
    end else if (ce) begin
      if (cmdGo && (state_r == shc_pkg::SHC_RUN_FULL || state_r == shc_pkg::SHC_RUN_SLOW)) begin
        edgeMode_r <= cmdEdge;
        wuSel_r <= cmdWuSel;
      end
    end
  end

  // resume address taken from the core as the command is accepted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resumePc <= '0;
    end else if (ce) begin
      if (cmdGo && (state_r == shc_pkg::SHC_RUN_FULL || state_r == shc_pkg::SHC_RUN_SLOW)) begin
        resumePc <= nextPc;
      end
    end
  end

  // clock control: only meaningful in dual-clock mode; leaving standby
  // or slow always lands in full speed, so the slow request is dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dualMode_r <= 1'b0;
      slowReq_r <= 1'b0;
    end else if (ce) begin
      if (state_r == shc_pkg::SHC_STANDBY || state_r == shc_pkg::SHC_WARMUP) begin
        slowReq_r <= 1'b0;
      end else if (ctlWrite) begin
        dualMode_r <= dat_i[shc_pkg::CTL_DUAL_BIT];
        slowReq_r <= dat_i[shc_pkg::CTL_SLOW_BIT] && dat_i[shc_pkg::CTL_DUAL_BIT];
      end
    end
  end

  // timer is cleared on the way into standby or warm-up and frozen in standby
  always_comb begin
    tmrBus.clear = (state_r != shc_pkg::SHC_STANDBY && state_nxt == shc_pkg::SHC_STANDBY)
                || (state_r != shc_pkg::SHC_WARMUP && state_nxt == shc_pkg::SHC_WARMUP);
    tmrBus.run = (state_r != shc_pkg::SHC_STANDBY);
  end

  // oscillator and core enables, registered from the next state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hiOscEn <= 1'b1;
      loOscEn <= 1'b0;
      coreRunEn <= 1'b1;
      inStandby <= 1'b0;
      lowOscPinsAsIo <= 1'b1;
    end else if (ce) begin
      // high oscillator restarts for warm-up; off in standby and slow
      hiOscEn <= (state_nxt == shc_pkg::SHC_RUN_FULL)
              || (state_nxt == shc_pkg::SHC_WARMUP);
      // low oscillator runs only in dual-clock mode and never in standby
      loOscEn <= dualMode_r && (state_nxt != shc_pkg::SHC_STANDBY);
      // core frozen, not reset, so memory and registers survive
      coreRunEn <= (state_nxt == shc_pkg::SHC_RUN_FULL)
                || (state_nxt == shc_pkg::SHC_RUN_SLOW);
      inStandby <= (state_nxt == shc_pkg::SHC_STANDBY);
      lowOscPinsAsIo <= !dualMode_r;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdData = 32'h0000_0000;
    case (adrHit)
      shc_pkg::OFS_STANDBY_CMD: begin
        rdData[shc_pkg::CMD_WU_LSB +: 2] = wuSel_r;
        rdData[shc_pkg::CMD_EDGE_BIT] = edgeMode_r;
      end
      shc_pkg::OFS_CLOCK_CTRL: begin
        rdData[shc_pkg::CTL_DUAL_BIT] = dualMode_r;
        rdData[shc_pkg::CTL_SLOW_BIT] = slowReq_r;
      end
      shc_pkg::OFS_CLOCK_STAT: begin
        // single-clock: 1 means pin low; dual-clock: 1 means low-speed run
        rdData[shc_pkg::STAT_STATE_BIT] = dualMode_r ? (state_r == shc_pkg::SHC_RUN_SLOW)
                                                     : !pinSync;
        rdData[shc_pkg::STAT_LOOSC_BIT] = loOscEn;
      end
      shc_pkg::OFS_AUX_STAT: begin
        rdData[shc_pkg::AUX_PIN_BIT] = pinSync;
      end
      shc_pkg::OFS_RESUME_PC: begin
        rdData[PC_W-1:0] = resumePc;
      end
      default: rdData = 32'h0000_0000;
    endcase
  end

  // every request acked one cycle later; ack drops the cycle after
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (ce) begin
      ack_o <= busReq;
      if (busReq && !we_i) begin
        dat_o <= rdData;
      end
    end
  end
endmodule

/* test/shc_pin_source.sv */
// standby pin source model: follows the request one or six cycles late
`timescale 1ns/100ps
module shc_pin_source (
  input wire logic clk,
  input wire logic pinReq,
  input wire logic pinSlow,
  output logic standbyPin
);
  logic [5:0] hist_r;
  initial hist_r = 6'h0;
  always @(posedge clk) hist_r <= {hist_r[4:0], pinReq};
  // switch pinSlow only while the request is steady, or the pin glitches
  assign standbyPin = pinSlow ? hist_r[5] : hist_r[0];
endmodule

/* test/shc_properties.sv */
// concurrent checks on the standby hold controller ports
`timescale 1ns/100ps
module shc_properties #(
  parameter int PC_W = 12,
  parameter int WU_TAP0 = 12,
  parameter int WU_TAP1 = 14,
  parameter int WU_TAP2 = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [shc_pkg::ADR_W-1:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  input wire logic [PC_W-1:0] nextPc,
  input wire logic [PC_W-1:0] resumePc,
  input wire logic coreRunEn,
  input wire logic standbyPin,
  input wire logic hiOscEn,
  input wire logic loOscEn,
  input wire logic inStandby
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic goW;
  logic edgeMode_r;
  logic [1:0] wuSel_r;
  logic [19:0] wuCnt_r;
  int tap;
  // a go written while stopped is ignored, so only run-state writes count
  assign goW = cyc_i && stb_i && !ack_o && we_i && coreRunEn
    && adr_i == shc_pkg::OFS_STANDBY_CMD && dat_i[shc_pkg::CMD_GO_BIT];
  assign tap = wuSel_r == 2'h0 ? WU_TAP0 : (wuSel_r == 2'h1 ? WU_TAP1 : WU_TAP2);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edgeMode_r <= 1'b0;
      wuSel_r <= 2'h0;
    end else if (goW) begin
      edgeMode_r <= dat_i[shc_pkg::CMD_EDGE_BIT];
      wuSel_r <= dat_i[shc_pkg::CMD_WU_LSB +: 2];
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wuCnt_r <= 20'h0;
    end else begin
      wuCnt_r <= (coreRunEn || inStandby) ? 20'h0 : wuCnt_r + 20'h1;
    end
  end
  property p_stby_off;
    inStandby |-> !hiOscEn && !loOscEn && !coreRunEn;
  endproperty
  a_stby_off: assert property (p_stby_off)
    else $error("oscillator or core on in standby");
  property p_warm_start;
    $fell(inStandby) |-> !coreRunEn ##1 (hiOscEn && !coreRunEn);
  endproperty
  a_warm_start: assert property (p_warm_start)
    else $error("warm-up start wrong");
  property p_warm_len;
    $rose(coreRunEn) |-> hiOscEn && wuCnt_r + 1 >= (1 << tap) && wuCnt_r <= (1 << tap) + 3;
  endproperty
  a_warm_len: assert property (p_warm_len)
    else $error("warm-up length wrong");
  property p_resume_pc;
    goW |=> resumePc == $past(nextPc);
  endproperty
  a_resume_pc: assert property (p_resume_pc)
    else $error("resume address not captured");
  property p_edge_entry;
    goW && dat_i[shc_pkg::CMD_EDGE_BIT] |-> ##[1:2] inStandby;
  endproperty
  a_edge_entry: assert property (p_edge_entry)
    else $error("edge mode command did not stop");
  property p_level_busy;
    goW && !dat_i[shc_pkg::CMD_EDGE_BIT] && standbyPin && $past(standbyPin, 2)
      |-> ##2 (!inStandby && !coreRunEn) [*2];
  endproperty
  a_level_busy: assert property (p_level_busy)
    else $error("level command with pin high misbehaved");
  property p_level_rel;
    inStandby && !edgeMode_r && standbyPin |-> ##[1:6] !inStandby;
  endproperty
  a_level_rel: assert property (p_level_rel)
    else $error("level release missing");
  property p_edge_rel;
    inStandby && edgeMode_r && $rose(standbyPin) |-> ##[1:7] !inStandby;
  endproperty
  a_edge_rel: assert property (p_edge_rel)
    else $error("edge release missing");
  c_edge: cover property (goW && dat_i[shc_pkg::CMD_EDGE_BIT]);
  c_busy: cover property (goW && standbyPin && !dat_i[shc_pkg::CMD_EDGE_BIT]);
  c_slow: cover property ($fell(hiOscEn) && !inStandby);
endmodule
bind standby_hold_controller shc_properties #(.PC_W(PC_W), .WU_TAP0(WU_TAP0),
  .WU_TAP1(WU_TAP1), .WU_TAP2(WU_TAP2)) i_shc_properties (.clk(clk), .rst_n(rst_n),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o),
  .nextPc(nextPc), .resumePc(resumePc), .coreRunEn(coreRunEn), .standbyPin(standbyPin),
  .hiOscEn(hiOscEn), .loOscEn(loOscEn), .inStandby(inStandby));

/* test/standby_hold_controller_test.sv */
// self-checking bench for the standby hold controller
`timescale 1ns/100ps
module standby_hold_controller_test;
  logic clk, rst_n, cyc, stb, we, ack, coreRunEn, hiOscEn, loOscEn, pinsIo, inStandby;
  logic pinReq, pinSlow, standbyPin, ce;
  logic [3:0] sel;
  logic [7:0] adr;
  logic [31:0] datI, datO, q;
  logic [11:0] nextPc, resumePc;
  int mismatches, checkCount, n;
  standby_hold_controller #(.WU_TAP0(2), .WU_TAP1(3), .WU_TAP2(4)) i_standby_hold_controller (
    .clk(clk), .rst_n(rst_n), .ce(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .dat_i(datI), .sel_i(sel), .dat_o(datO), .ack_o(ack), .nextPc(nextPc),
    .coreRunEn(coreRunEn), .resumePc(resumePc), .standbyPin(standbyPin), .hiOscEn(hiOscEn),
    .loOscEn(loOscEn), .lowOscPinsAsIo(pinsIo), .inStandby(inStandby));
  shc_pin_source i_shc_pin_source (.clk(clk), .pinReq(pinReq), .pinSlow(pinSlow),
    .standbyPin(standbyPin));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datI <= d;
    @(posedge clk);
    while (ack !== 1'b1 && k < 99) begin
      @(posedge clk);
      k++;
    end
    chk(32'(k < 99), 32'h1);
    q = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // the call may come late in the warm-up, hence the loose lower bound
  task automatic run(input int t);
    int k;
    k = 0;
    n = 0;
    while (coreRunEn !== 1'b1 && k < 999) begin
      @(posedge clk);
      k++;
      if (!inStandby) n++;
    end
    chk(32'(n >= (1 << t) - 3 && n <= (1 << t) + 4), 32'h1);
  endtask
  task automatic t_reset();
    chk(32'({hiOscEn, loOscEn, pinsIo, coreRunEn, inStandby}), 32'h16);
    bus(1'b0, 8'h08, 32'h0);
    chk(q, 32'h1);
    pinReq <= 1'b1;
    tick(6);
    bus(1'b0, 8'h08, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 8'h0c, 32'h0);
    chk(q, 32'h8);
    bus(1'b0, 8'h1c, 32'h0);
    chk(q, 32'h0);
    // clock enable low must freeze the pin synchroniser as well
    ce <= 1'b0;
    pinReq <= 1'b0;
    tick(8);
    ce <= 1'b1;
    bus(1'b0, 8'h0c, 32'h0);
    chk(q, 32'h8);
    tick(4);
    bus(1'b0, 8'h0c, 32'h0);
    chk(q, 32'h0);
    pinReq <= 1'b1;
    tick(6);
  endtask
  task automatic t_edge();
    for (int s = 0; s < 4; s++) begin
      nextPc <= 12'h100 + 12'(s);
      pinSlow <= s[0];
      bus(1'b1, 8'h00, 32'h9 + 32'(2 * s));
      chk(32'({inStandby, coreRunEn, hiOscEn}), 32'h4);
      nextPc <= 12'h0;
      pinReq <= 1'b0;
      tick(12);
      bus(1'b0, 8'h10, 32'h0);
      chk(q, 32'h100 + 32'(s));
      chk(32'(inStandby), 32'h1);
      pinReq <= 1'b1;
      // select 3 runs as long as select 2
      run(s == 3 ? 4 : s + 2);
      chk(32'(resumePc), 32'h100 + 32'(s));
    end
  endtask
  task automatic t_level();
    pinReq <= 1'b0;
    tick(12);
    bus(1'b1, 8'h00, 32'h1);
    tick(12);
    chk(32'(inStandby), 32'h1);
    pinReq <= 1'b1;
    run(2);
    bus(1'b1, 8'h00, 32'h1);
    chk(32'({inStandby, coreRunEn}), 32'h0);
    run(2);
  endtask
  task automatic t_rst();
    pinReq <= 1'b0;
    tick(12);
    bus(1'b1, 8'h00, 32'h1);
    chk(32'(inStandby), 32'h1);
    rst_n <= 1'b0;
    tick(1);
    chk(32'({inStandby, coreRunEn}), 32'h1);
    // two edges of reset, so no past-value check sees the reset step
    tick(1);
    rst_n <= 1'b1;
    tick(1);
  endtask
  task automatic t_slow();
    pinReq <= 1'b1;
    // a write without byte lane 0 must leave the control fields alone
    sel <= 4'he;
    bus(1'b1, 8'h04, 32'h3);
    sel <= 4'hf;
    bus(1'b0, 8'h04, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 8'h04, 32'h1);
    bus(1'b0, 8'h08, 32'h0);
    chk(q, 32'h2);
    bus(1'b1, 8'h04, 32'h3);
    bus(1'b0, 8'h08, 32'h0);
    chk(q, 32'h3);
    chk(32'({hiOscEn, pinsIo}), 32'h0);
    bus(1'b1, 8'h00, 32'h9);
    chk(32'({inStandby, loOscEn}), 32'h2);
    pinReq <= 1'b0;
    tick(12);
    pinReq <= 1'b1;
    run(2);
    bus(1'b0, 8'h08, 32'h0);
    chk(q, 32'h2);
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && checkCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    {cyc, stb, we, pinReq, pinSlow} = 5'h0;
    adr = 8'h0;
    datI = 32'h0;
    sel = 4'hf;
    ce = 1'b1;
    nextPc = 12'h0;
    mismatches = 0;
    checkCount = 0;
    tick(4);
    rst_n <= 1'b1;
    tick(1);
    t_reset();
    t_edge();
    t_level();
    t_rst();
    t_slow();
    end_of_test();
  end
  initial begin
    #100000;
    mismatches++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
